// >>> qsg_pkg.sv
package qsg_pkg;

    // ------------------------------------------------------------
    // widths and register selects
    // ------------------------------------------------------------
    localparam int           DATA_W     = 16;
    localparam int           SEL_W      = 3;
    localparam logic [2:0]   SEL_EVENT  = 3'h0;
    localparam logic [2:0]   SEL_COND   = 3'h1;
    localparam logic [2:0]   SEL_ENABLE = 3'h2;
    localparam logic [2:0]   SEL_FALL   = 3'h3;
    localparam logic [2:0]   SEL_RISE   = 3'h4;

    // ------------------------------------------------------------
    // condition bit positions
    // ------------------------------------------------------------
    localparam int BIT_HIGH_VOLT   = 0;
    localparam int BIT_OVERCURRENT = 1;
    localparam int BIT_LOCAL_KEY   = 3;
    localparam int BIT_HEAT_LIMIT  = 4;
    localparam int BIT_SENSE_OPEN  = 5;
    localparam int BIT_AUX_UNREG   = 8;
    localparam int BIT_INHIBIT     = 9;
    localparam int BIT_MAIN_UNREG  = 10;
    localparam int BIT_AUX_CURRENT = 12;
    localparam int BIT_MEAS_OVER   = 14;

    // ------------------------------------------------------------
    // masks and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DEFINED_MASK = 16'h573b;
    localparam logic [15:0] WRITE_MASK   = 16'h7fff;
    localparam logic [15:0] RISE_RESET   = 16'h7fff;
    localparam logic [15:0] FALL_RESET   = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;

    // mask off bit 15 of a written value, leaving the accepted 0..32767 range
    function automatic logic [15:0] fit_write(input logic [15:0] value);
        return value & WRITE_MASK;
    endfunction : fit_write

endpackage : qsg_pkg

// >>> qsg_edge_filter.sv
// ------------------------------------------------------------
// per-bit transition filter
// ------------------------------------------------------------
module qsg_edge_filter #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] cond_i,
    input  wire logic [W-1:0] prev_i,
    input  wire logic [W-1:0] rise_filter_i,
    input  wire logic [W-1:0] fall_filter_i,
    output logic      [W-1:0] set_o
);

    // rising edge through rise filter, falling edge through fall filter
    assign set_o = (rise_filter_i & ~prev_i & cond_i)
                 | (fall_filter_i & prev_i & ~cond_i);

endmodule : qsg_edge_filter

// >>> qsg_status_group.sv
// Functional notes
// - condition register shows live inputs
// - event bits latch until cleared
// - event read returns value then clears
// - fall filter bit catches 1-to-0 edges
// - rise filter bit catches 0-to-1 edges
// - enable mask ORs events into summary
// - preset loads filters; writes clipped, read back
// - bit 0 high output voltage trip
// - bit 1 overcurrent trip
// - bit 3 local key pressed
// - bit 4 heat limit trip
// - bit 5 sense lead open
// - bit 8 aux output unregulated, dual only
// - bit 9 remote inhibit active
// - bit 10 main output unregulated
// - bit 12 aux current trip, dual only
// - bit 14 measurement overrange
// - preset sets rise, clears fall, enable
module qsg_status_group #(
    parameter bit DUAL_OUTPUT = 1'b1
) (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        high_output_voltage_trip_i,
    input  wire logic        overcurrent_trip_i,
    input  wire logic        local_key_pressed_i,
    input  wire logic        heat_limit_trip_i,
    input  wire logic        sense_lead_open_i,
    input  wire logic        aux_output_not_in_regulation_i,
    input  wire logic        remote_inhibit_active_i,
    input  wire logic        main_output_not_in_regulation_i,
    input  wire logic        aux_output_current_trip_i,
    input  wire logic        measurement_overrange_i,
    input  wire logic [2:0]  reg_sel_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        status_preset_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic             warning_summary_bit_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] warning_live_condition;
    logic [15:0] warning_event_latch;
    logic [15:0] warning_enable_mask;
    logic [15:0] warning_falling_filter;
    logic [15:0] warning_rising_filter;
    logic [15:0] cond_prev;
    logic [15:0] set_vec;
    logic [15:0] next_event;
    logic [15:0] next_enable;
    logic [15:0] read_word;
    logic        event_clear;
    logic        wr_enable;
    logic        wr_fall;
    logic        wr_rise;

    // ------------------------------------------------------------
    // live condition vector
    // ------------------------------------------------------------

    // unlisted bits stay tied low
    always_comb begin
        warning_live_condition = qsg_pkg::ZERO_WORD;
        warning_live_condition[qsg_pkg::BIT_HIGH_VOLT]   = high_output_voltage_trip_i;
        warning_live_condition[qsg_pkg::BIT_OVERCURRENT] = overcurrent_trip_i;
        warning_live_condition[qsg_pkg::BIT_LOCAL_KEY]   = local_key_pressed_i;
        warning_live_condition[qsg_pkg::BIT_HEAT_LIMIT]  = heat_limit_trip_i;
        warning_live_condition[qsg_pkg::BIT_SENSE_OPEN]  = sense_lead_open_i;
        warning_live_condition[qsg_pkg::BIT_AUX_UNREG]   =
            DUAL_OUTPUT & aux_output_not_in_regulation_i;
        warning_live_condition[qsg_pkg::BIT_INHIBIT]     = remote_inhibit_active_i;
        warning_live_condition[qsg_pkg::BIT_MAIN_UNREG]  =
            main_output_not_in_regulation_i;
        warning_live_condition[qsg_pkg::BIT_AUX_CURRENT] =
            DUAL_OUTPUT & aux_output_current_trip_i;
        warning_live_condition[qsg_pkg::BIT_MEAS_OVER]   = measurement_overrange_i;
    end

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------

    // write and clearing-read strobes
    assign event_clear = reg_rd_i && (reg_sel_i == qsg_pkg::SEL_EVENT);
    assign wr_enable   = reg_wr_i && (reg_sel_i == qsg_pkg::SEL_ENABLE);
    assign wr_fall     = reg_wr_i && (reg_sel_i == qsg_pkg::SEL_FALL);
    assign wr_rise     = reg_wr_i && (reg_sel_i == qsg_pkg::SEL_RISE);

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------

    // previous-cycle condition for edge compare
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cond_prev <= qsg_pkg::ZERO_WORD;
        end else begin
            cond_prev <= warning_live_condition;
        end
    end

    // transition filters
    qsg_edge_filter #(
        .W (qsg_pkg::DATA_W)
    ) u_edge_filter (
        .cond_i        (warning_live_condition),
        .prev_i        (cond_prev),
        .rise_filter_i (warning_rising_filter),
        .fall_filter_i (warning_falling_filter),
        .set_o         (set_vec)
    );

    // ------------------------------------------------------------
    // event latch
    // ------------------------------------------------------------

    // new sets survive a clearing read
    always_comb begin
        next_event = event_clear ? qsg_pkg::ZERO_WORD : warning_event_latch;
        next_event = (next_event | set_vec) & qsg_pkg::DEFINED_MASK;
    end

    // sticky event bits
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warning_event_latch <= qsg_pkg::ZERO_WORD;
        end else begin
            warning_event_latch <= next_event;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------

    // enable mask, preset wins over a write
    always_comb begin
        next_enable = warning_enable_mask;
        if (status_preset_i) begin
            next_enable = qsg_pkg::ENABLE_RESET;
        end else if (wr_enable) begin
            next_enable = qsg_pkg::fit_write(reg_wdata_i);
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warning_enable_mask <= qsg_pkg::ENABLE_RESET;
        end else begin
            warning_enable_mask <= next_enable;
        end
    end

    // falling edge filter
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warning_falling_filter <= qsg_pkg::FALL_RESET;
        end else if (status_preset_i) begin
            warning_falling_filter <= qsg_pkg::FALL_RESET;
        end else if (wr_fall) begin
            warning_falling_filter <= qsg_pkg::fit_write(reg_wdata_i);
        end
    end

    // rising edge filter
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warning_rising_filter <= qsg_pkg::RISE_RESET;
        end else if (status_preset_i) begin
            warning_rising_filter <= qsg_pkg::RISE_RESET;
        end else if (wr_rise) begin
            warning_rising_filter <= qsg_pkg::fit_write(reg_wdata_i);
        end
    end

    // ------------------------------------------------------------
    // summary bit
    // ------------------------------------------------------------

    // or of enabled events, aligned with the latch
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warning_summary_bit_o <= 1'b0;
        end else begin
            warning_summary_bit_o <= |(next_event & next_enable);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // read mux, unmapped selects return zero
    always_comb begin
        case (reg_sel_i)
            qsg_pkg::SEL_EVENT:  read_word = warning_event_latch;
            qsg_pkg::SEL_COND:   read_word = warning_live_condition;
            qsg_pkg::SEL_ENABLE: read_word = warning_enable_mask;
            qsg_pkg::SEL_FALL:   read_word = warning_falling_filter;
            qsg_pkg::SEL_RISE:   read_word = warning_rising_filter;
            default:             read_word = qsg_pkg::ZERO_WORD;
        endcase
    end

    // registered read data and valid pulse
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o  <= qsg_pkg::ZERO_WORD;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= read_word;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // condition read shows inputs of the read cycle
    chk_cond_live_read: assert property (
        reg_rd_i && reg_sel_i == qsg_pkg::SEL_COND
        |=> reg_rvalid_o && reg_rdata_o == $past(warning_live_condition))
        else $error("condition read does not match live inputs");

    // set bits persist without a clearing read
    chk_event_sticky_hold: assert property (
        !event_clear
        |=> (warning_event_latch & $past(warning_event_latch))
            == $past(warning_event_latch))
        else $error("event bit lost without a clearing read");

    // clearing read returns old value, keeps only new sets
    chk_read_then_clear: assert property (
        event_clear
        |=> reg_rdata_o == $past(warning_event_latch)
            && warning_event_latch == ($past(set_vec) & qsg_pkg::DEFINED_MASK))
        else $error("event read did not return then clear");

    // a filtered falling edge sets its event bit
    chk_fall_edge_sets: assert property (
        (warning_falling_filter & cond_prev & ~warning_live_condition) != 16'h0000
        |=> (warning_event_latch
             & $past(warning_falling_filter & cond_prev & ~warning_live_condition))
            == $past(warning_falling_filter & cond_prev & ~warning_live_condition))
        else $error("falling edge did not set event");

    // a filtered rising edge sets its event bit
    chk_rise_edge_sets: assert property (
        (warning_rising_filter & ~cond_prev & warning_live_condition) != 16'h0000
        |=> (warning_event_latch
             & $past(warning_rising_filter & ~cond_prev & warning_live_condition))
            == $past(warning_rising_filter & ~cond_prev & warning_live_condition))
        else $error("rising edge did not set event");

    // bits with neither filter never rise in the latch
    chk_unfiltered_quiet: assert property (
        ##1 (warning_event_latch & ~$past(warning_event_latch)
             & ~$past(warning_rising_filter | warning_falling_filter)) == 16'h0000)
        else $error("event set with both filters clear");

    // edges compare against the previous cycle only
    chk_no_edge_no_set: assert property (
        warning_live_condition == cond_prev && !event_clear
        |=> warning_event_latch == $past(warning_event_latch))
        else $error("event changed without an edge");

    // summary is or of enabled events
    chk_summary_or: assert property (
        warning_summary_bit_o == (|(warning_event_latch & warning_enable_mask)))
        else $error("summary bit disagrees with enabled events");

    // preset loads filter and enable values
    chk_preset_values: assert property (
        status_preset_i
        |=> warning_rising_filter == qsg_pkg::RISE_RESET
            && warning_falling_filter == qsg_pkg::FALL_RESET
            && warning_enable_mask == qsg_pkg::ENABLE_RESET)
        else $error("preset did not load filters and enable");

    // rise filter write reads back clipped to range
    chk_filter_readback: assert property (
        wr_rise && !status_preset_i
        ##1 reg_rd_i && reg_sel_i == qsg_pkg::SEL_RISE
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & qsg_pkg::WRITE_MASK))
        else $error("rise filter readback wrong");

    // stored writable registers never exceed 32767
    chk_write_range: assert property (
        ((warning_enable_mask | warning_rising_filter | warning_falling_filter)
         & ~qsg_pkg::WRITE_MASK) == 16'h0000)
        else $error("register holds value above range");

    // unused bits stay zero in condition and event
    chk_unused_zero: assert property (
        ((warning_live_condition | warning_event_latch)
         & ~qsg_pkg::DEFINED_MASK) == 16'h0000)
        else $error("unused status bit is set");

    // flag inputs land on their bit positions
    chk_flag_mapping: assert property (
        warning_live_condition[qsg_pkg::BIT_HIGH_VOLT] == high_output_voltage_trip_i
        && warning_live_condition[qsg_pkg::BIT_MEAS_OVER] == measurement_overrange_i
        && warning_live_condition[qsg_pkg::BIT_INHIBIT] == remote_inhibit_active_i)
        else $error("flag bit mapping wrong");

    // remaining flag inputs land on their bit positions
    chk_flag_mapping_rest: assert property (
        warning_live_condition[qsg_pkg::BIT_OVERCURRENT] == overcurrent_trip_i
        && warning_live_condition[qsg_pkg::BIT_LOCAL_KEY] == local_key_pressed_i
        && warning_live_condition[qsg_pkg::BIT_HEAT_LIMIT] == heat_limit_trip_i
        && warning_live_condition[qsg_pkg::BIT_SENSE_OPEN] == sense_lead_open_i
        && warning_live_condition[qsg_pkg::BIT_MAIN_UNREG] == main_output_not_in_regulation_i
        && warning_live_condition[qsg_pkg::BIT_AUX_UNREG]
           == (DUAL_OUTPUT & aux_output_not_in_regulation_i)
        && warning_live_condition[qsg_pkg::BIT_AUX_CURRENT]
           == (DUAL_OUTPUT & aux_output_current_trip_i))
        else $error("second group of flag bits misplaced");

    // a read answers one cycle later with the selected word
    chk_read_answer: assert property (
        reg_rd_i
        |=> reg_rvalid_o && reg_rdata_o == $past(read_word))
        else $error("read answer missing or wrong");

    // without a read, valid stays low and data holds
    chk_rdata_hold: assert property (
        !reg_rd_i
        |=> !reg_rvalid_o && reg_rdata_o == $past(reg_rdata_o))
        else $error("read data moved without a read");

    // an edge set lands even beside a clearing read
    chk_set_beats_clear: assert property (
        (set_vec & qsg_pkg::DEFINED_MASK) != qsg_pkg::ZERO_WORD
        |=> (warning_event_latch & $past(set_vec & qsg_pkg::DEFINED_MASK))
            == $past(set_vec & qsg_pkg::DEFINED_MASK))
        else $error("edge set lost beside a clearing read");

    // enable write stores the clipped value
    chk_enable_write: assert property (
        wr_enable && !status_preset_i
        |=> warning_enable_mask == ($past(reg_wdata_i) & qsg_pkg::WRITE_MASK))
        else $error("enable write not stored");

endmodule : qsg_status_group

// >>> questionable_status_group_tb.sv
module questionable_status_group_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and case table
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] c0;
        logic [15:0] c1;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] en;
        logic [15:0] ev;
        logic        sum;
    } qsg_row_s;

    logic        core_clk_i;
    logic        sys_rst_i;
    logic [15:0] cond;
    logic [2:0]  reg_sel_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [15:0] reg_wdata_i;
    logic        status_preset_i;
    logic [15:0] reg_rdata_o;
    logic        reg_rvalid_o;
    logic        warning_summary_bit_o;
    logic [15:0] v;
    int          n_fail;
    int          checked;

    // c0, c1, rise, fall, enable, expected event, expected summary
    qsg_row_s rows [15] = '{
        '{16'h0000, 16'h0001, 16'h7fff, 16'h0000, 16'h0001, 16'h0001, 1'b1},
        '{16'h0000, 16'h0002, 16'h7fff, 16'h0000, 16'h0002, 16'h0002, 1'b1},
        '{16'h0000, 16'h0008, 16'h7fff, 16'h0000, 16'h0008, 16'h0008, 1'b1},
        '{16'h0000, 16'h0010, 16'h7fff, 16'h0000, 16'h0010, 16'h0010, 1'b1},
        '{16'h0000, 16'h0020, 16'h7fff, 16'h0000, 16'h0020, 16'h0020, 1'b1},
        '{16'h0000, 16'h0100, 16'h7fff, 16'h0000, 16'h0100, 16'h0100, 1'b1},
        '{16'h0000, 16'h0200, 16'h7fff, 16'h0000, 16'h0200, 16'h0200, 1'b1},
        '{16'h0000, 16'h0400, 16'h7fff, 16'h0000, 16'h0400, 16'h0400, 1'b1},
        '{16'h0000, 16'h1000, 16'h7fff, 16'h0000, 16'h1000, 16'h1000, 1'b1},
        '{16'h0000, 16'h4000, 16'h7fff, 16'h0000, 16'h4000, 16'h4000, 1'b1},
        '{16'h573b, 16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 1'b0},
        '{16'h573b, 16'h0000, 16'h0000, 16'h7fff, 16'h7fff, 16'h573b, 1'b1},
        '{16'h0000, 16'h573b, 16'h0000, 16'h0000, 16'h7fff, 16'h0000, 1'b0},
        '{16'h0000, 16'hffff, 16'h7fff, 16'h7fff, 16'h0000, 16'h573b, 1'b0},
        '{16'h0403, 16'h0010, 16'h0010, 16'h0001, 16'h0001, 16'h0011, 1'b1}
    };

    qsg_status_group #(
        .DUAL_OUTPUT(1'b1)
    ) u_qsg_status_group (
        .core_clk_i                      (core_clk_i),
        .sys_rst_i                       (sys_rst_i),
        .high_output_voltage_trip_i      (cond[qsg_pkg::BIT_HIGH_VOLT]),
        .overcurrent_trip_i              (cond[qsg_pkg::BIT_OVERCURRENT]),
        .local_key_pressed_i             (cond[qsg_pkg::BIT_LOCAL_KEY]),
        .heat_limit_trip_i               (cond[qsg_pkg::BIT_HEAT_LIMIT]),
        .sense_lead_open_i               (cond[qsg_pkg::BIT_SENSE_OPEN]),
        .aux_output_not_in_regulation_i  (cond[qsg_pkg::BIT_AUX_UNREG]),
        .remote_inhibit_active_i         (cond[qsg_pkg::BIT_INHIBIT]),
        .main_output_not_in_regulation_i (cond[qsg_pkg::BIT_MAIN_UNREG]),
        .aux_output_current_trip_i       (cond[qsg_pkg::BIT_AUX_CURRENT]),
        .measurement_overrange_i         (cond[qsg_pkg::BIT_MEAS_OVER]),
        .reg_sel_i                       (reg_sel_i),
        .reg_wr_i                        (reg_wr_i),
        .reg_rd_i                        (reg_rd_i),
        .reg_wdata_i                     (reg_wdata_i),
        .status_preset_i                 (status_preset_i),
        .reg_rdata_o                     (reg_rdata_o),
        .reg_rvalid_o                    (reg_rvalid_o),
        .warning_summary_bit_o           (warning_summary_bit_o)
    );

    // 250 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------
    task automatic step();
        @(posedge core_clk_i);
        #1;
    endtask : step

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check

    // one-cycle write strobe, then an idle edge
    task automatic wr(input logic [2:0] sel, input logic [15:0] data);
        reg_sel_i = sel;
        reg_wdata_i = data;
        reg_wr_i = 1'b1;
        step();
        reg_wr_i = 1'b0;
        step();
    endtask : wr

    // read strobe; rvalid and data stand the cycle after the taking edge
    task automatic rd(input logic [2:0] sel, output logic [15:0] val);
        reg_sel_i = sel;
        reg_rd_i = 1'b1;
        step();
        reg_rd_i = 1'b0;
        check("rvalid", 16'h0001, {15'h0, reg_rvalid_o});
        val = reg_rdata_o;
        step();
        check("rvalid drop", 16'h0000, {15'h0, reg_rvalid_o});
    endtask : rd

    task automatic rd_chk(input logic [2:0] sel, input logic [15:0] exp, input string what);
        logic [15:0] got;
        rd(sel, got);
        check(what, exp, got);
    endtask : rd_chk

    task automatic sum_chk(input logic exp);
        check("summary", {15'h0, exp}, {15'h0, warning_summary_bit_o});
    endtask : sum_chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        checked = 0;
        sys_rst_i = 1'b1;
        cond = 16'h0000;
        reg_sel_i = 3'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 16'h0000;
        status_preset_i = 1'b0;
        repeat (20) @(posedge core_clk_i);
        #1;
        check("rdata in reset", 16'h0000, reg_rdata_o);
        sum_chk(1'b0);
        sys_rst_i = 1'b0;
        rd_chk(qsg_pkg::SEL_RISE, 16'h7fff, "rise reset");
        rd_chk(qsg_pkg::SEL_FALL, 16'h0000, "fall reset");
        rd_chk(qsg_pkg::SEL_ENABLE, 16'h0000, "enable reset");
        rd_chk(qsg_pkg::SEL_EVENT, 16'h0000, "event reset");
        $display("test reset done");
        // clipping, read-only places and an unmapped select
        wr(qsg_pkg::SEL_FALL, 16'hffff);
        rd_chk(qsg_pkg::SEL_FALL, 16'h7fff, "fall clip");
        wr(qsg_pkg::SEL_ENABLE, 16'hffff);
        rd_chk(qsg_pkg::SEL_ENABLE, 16'h7fff, "enable clip");
        wr(qsg_pkg::SEL_EVENT, 16'hffff);
        rd_chk(qsg_pkg::SEL_EVENT, 16'h0000, "event write");
        wr(qsg_pkg::SEL_COND, 16'hffff);
        rd_chk(qsg_pkg::SEL_COND, 16'h0000, "cond write");
        rd_chk(3'h5, 16'h0000, "unmapped");
        $display("test access done");
        // table of edge, filter and mask cases
        for (int i = 0; i < 15; i++) begin
            wr(qsg_pkg::SEL_RISE, rows[i].rise);
            wr(qsg_pkg::SEL_FALL, rows[i].fall);
            wr(qsg_pkg::SEL_ENABLE, rows[i].en);
            cond = rows[i].c0;
            step();
            step();
            rd(qsg_pkg::SEL_EVENT, v);
            cond = rows[i].c1;
            step();
            step();
            sum_chk(rows[i].sum);
            rd_chk(qsg_pkg::SEL_COND, rows[i].c1 & qsg_pkg::DEFINED_MASK, "cond");
            rd_chk(qsg_pkg::SEL_EVENT, rows[i].ev, "event");
        end
        $display("test table done");
        // event held for many cycles, then cleared by one read
        wr(qsg_pkg::SEL_RISE, 16'h7fff);
        wr(qsg_pkg::SEL_FALL, 16'h0000);
        wr(qsg_pkg::SEL_ENABLE, 16'h7fff);
        cond = 16'h0000;
        step();
        step();
        rd(qsg_pkg::SEL_EVENT, v);
        cond = 16'h0001;
        repeat (5) step();
        sum_chk(1'b1);
        rd_chk(qsg_pkg::SEL_EVENT, 16'h0001, "event held");
        sum_chk(1'b0);
        rd_chk(qsg_pkg::SEL_EVENT, 16'h0000, "event cleared");
        // new edge in the same cycle as the clearing read
        cond = 16'h0003;
        rd(qsg_pkg::SEL_EVENT, v);
        check("read at set", 16'h0000, v);
        rd_chk(qsg_pkg::SEL_EVENT, 16'h0002, "set kept");
        $display("test clear done");
        // preset, alone and against a same-cycle write
        wr(qsg_pkg::SEL_RISE, 16'h0000);
        wr(qsg_pkg::SEL_FALL, 16'h1234);
        wr(qsg_pkg::SEL_ENABLE, 16'h00ff);
        status_preset_i = 1'b1;
        step();
        status_preset_i = 1'b0;
        step();
        rd_chk(qsg_pkg::SEL_RISE, 16'h7fff, "preset rise");
        rd_chk(qsg_pkg::SEL_FALL, 16'h0000, "preset fall");
        rd_chk(qsg_pkg::SEL_ENABLE, 16'h0000, "preset enable");
        reg_sel_i = qsg_pkg::SEL_FALL;
        reg_wdata_i = 16'h0055;
        reg_wr_i = 1'b1;
        status_preset_i = 1'b1;
        step();
        reg_wr_i = 1'b0;
        status_preset_i = 1'b0;
        step();
        rd_chk(qsg_pkg::SEL_FALL, 16'h0000, "preset wins");
        // write then read on the next edge, then read beside a write
        reg_sel_i = qsg_pkg::SEL_RISE;
        reg_wdata_i = 16'hc321;
        reg_wr_i = 1'b1;
        step();
        reg_wr_i = 1'b0;
        rd_chk(qsg_pkg::SEL_RISE, 16'h4321, "rise back to back");
        reg_wdata_i = 16'h0100;
        reg_wr_i = 1'b1;
        reg_rd_i = 1'b1;
        step();
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        check("read beside write", 16'h4321, reg_rdata_o);
        step();
        rd_chk(qsg_pkg::SEL_RISE, 16'h0100, "write beside read");
        $display("test preset done");
        // second reset in mid-run
        wr(qsg_pkg::SEL_FALL, 16'h0005);
        wr(qsg_pkg::SEL_RISE, 16'h0001);
        sys_rst_i = 1'b1;
        repeat (3) step();
        check("rdata in reset", 16'h0000, reg_rdata_o);
        sum_chk(1'b0);
        sys_rst_i = 1'b0;
        step();
        rd_chk(qsg_pkg::SEL_FALL, 16'h0000, "fall rereset");
        rd_chk(qsg_pkg::SEL_RISE, 16'h7fff, "rise rereset");
        $display("test rereset done");
        wrap_up();
    end

endmodule : questionable_status_group_tb
